// *** verilog/rcap_pkg.sv ***
// Shared constants and types of the read-command and address-pointer block.
// Assumes a byte-level serial bus slave on the same clock in front of it.
`default_nettype none
package rcap_pkg;
  // Command classes in the two top bits of the first byte
  localparam logic [1:0] CMD_CONFIG   = 2'h0;
  localparam logic [1:0] CMD_DATA     = 2'h1;
  localparam logic [1:0] CMD_DISPCTRL = 2'h2;
  localparam logic [1:0] CMD_ADDRESS  = 2'h3;
  // Data-command selectors in bits 5-4
  localparam logic [1:0] DSEL_WRITE   = 2'h0;
  localparam logic [1:0] DSEL_WRITE2  = 2'h1;
  localparam logic [1:0] DSEL_READ1   = 2'h2;
  localparam logic [1:0] DSEL_READ3   = 2'h3;
  // Write sub-selectors in bits 1-0
  localparam logic [1:0] WSEL_RTC     = 2'h0;
  localparam logic [1:0] WSEL_AUX     = 2'h3;
  // Read kinds: {group three, bits 1-0}
  localparam logic [2:0] RD_KEY       = 3'h0;
  localparam logic [2:0] RD_AUX       = 3'h1;
  localparam logic [2:0] RD_REMOTE    = 3'h2;
  localparam logic [2:0] RD_IRQ       = 3'h3;
  localparam logic [2:0] RD_RSVD      = 3'h4;
  localparam logic [2:0] RD_CFG       = 3'h5;
  localparam logic [2:0] RD_DISP      = 3'h6;
  localparam logic [2:0] RD_RTC       = 3'h7;
  // Byte counts of the fixed-length reads
  localparam logic [2:0] NB_KEY       = 3'h2;
  localparam logic [2:0] NB_AUX       = 3'h1;
  localparam logic [2:0] NB_REMOTE    = 3'h4;
  localparam logic [2:0] NB_IRQ       = 3'h2;
  localparam logic [2:0] NB_CFG       = 3'h5;
  // Address map
  localparam logic [4:0] DISP_FIRST   = 5'h10;
  localparam logic [4:0] DISP_LAST    = 5'h14;
  localparam logic [3:0] RTC_RESET    = 4'h0;
  localparam int         DISP_DEPTH   = 5;
  // Display control command bits
  localparam int         DC_HOTKEY_BIT = 5;
  localparam logic [1:0] DC_FP_HOTKEY = 2'h2;
  // Filler returned for reserved reads and reads past the end
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  // Configuration reset values
  localparam logic [7:0] RST_OUT_FMT  = 8'h2A;
  localparam logic [7:0] RST_DISP_PIN = 8'h03;
  localparam logic [7:0] RST_BRIGHT   = 8'h09;
  localparam logic [7:0] RST_WAKE     = 8'h00;
  // Field positions in the display-and-pin byte
  localparam int         DP_AUX0_DIR  = 3;
  localparam int         DP_AUX1_DIR  = 4;

  typedef struct packed {
    logic [7:0] wake_bank_two;
    logic [7:0] wake_bank_one;
    logic [7:0] brightness;
    logic [7:0] display_pin;
    logic [7:0] out_format;
  } rcap_cfg_type;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_req;
    logic       bit_adv;
    logic       nack;
  } rcap_bus_type;
endpackage
`default_nettype wire

// *** verilog/rcap_sync.sv ***
// Two-flop synchroniser for one asynchronous level.
// Assumes the level may change at any time relative to CLOCK.
`default_nettype none
module rcap_sync (
  // Clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** verilog/rcap_top.sv ***
// Command interpreter and address pointers behind the serial two-wire bus.
// Assumes a byte-level bus slave on CLOCK that matches the slave address,
// delivers received bytes, requests read bytes and clocks their bits out.
// Contract
// (RULE1) First byte after slave address is the command; unaddressed bytes ignored.
// (RULE2) Top bits 01 mean data command; bits 5-4 10/11 select read groups.
// (RULE3) Group one selector 00 returns two key-matrix bytes.
// (RULE4) Group one selector 01 returns aux pin one in bit 7, zero in 6.
// (RULE5) Group one selector 10 returns four remote control bytes.
// (RULE6) Group one selector 11 returns the interrupt status register.
// (RULE7) Group three selector 00 reserved; 01 returns configuration bytes.
// (RULE8) Group three selector 10 reads display memory from display pointer.
// (RULE9) Host sets clock address before reading clock memory.
// (RULE10) After reset: auto-increment, display pointer at 0x10; code takes the mode from the FIXED_ADDR input, which reset does not set.
// (RULE11) One address command then many data bytes, pointer advancing each.
// (RULE12) Data command without address continues from retained pointer.
// (RULE13) Display pointer wraps past the last location back to 0x10.
// (RULE14) Address command 11 plus 5 bits: 00-0F clock, 10-14 display.
// (RULE15) Fixed mode: pointer does not advance between bytes.
// (RULE16) Clock read without address uses held clock pointer.
// (RULE17) Clock write without address uses held clock pointer.
// (RULE18) Display write without address uses held display pointer.
// (RULE19) Up to five configuration bytes, least significant first.
// (RULE20) Second config byte: digits, lamps, aux dirs, irq enable, edges.
// (RULE21) Third config byte: display enable bit 4, dimming bits 3-0.
// (RULE22) Read bytes leave most significant bit first; host acks all but last.
`default_nettype none
module rcap_top (
  // Clock, reset, enable
  input  wire logic                  CLOCK,
  input  wire logic                  SRST,
  input  wire logic                  CLK_EN,
  // Byte link from the bus slave
  input  wire rcap_pkg::rcap_bus_type BUS,
  output logic                       TX_BIT,
  // Addressing mode
  input  wire logic                  FIXED_ADDR,
  // Read sources
  input  wire logic [15:0]           KEY_DATA,
  input  wire logic [31:0]           REMOTE_DATA,
  input  wire logic [15:0]           IRQ_STATUS,
  // Clock register space
  output logic [3:0]                 RTC_ADDR,
  input  wire logic [7:0]            RTC_RDATA,
  output logic                       RTC_WE,
  output logic [3:0]                 RTC_WADDR,
  output logic [7:0]                 RTC_WDATA,
  // Auxiliary pins
  input  wire logic                  AUX_PIN_ZERO_I,
  input  wire logic                  AUX_PIN_ONE_I,
  output logic [1:0]                 AUX_O,
  output logic [1:0]                 AUX_OE,
  // Configuration and display memory
  output rcap_pkg::rcap_cfg_type     CFG,
  output logic [39:0]                DISP_MEM
);
  import rcap_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_CFG, ST_WR_RTC, ST_WR_DISP, ST_WR_AUX, ST_HOTKEY,
    ST_READ, ST_IGNORE
  } rcap_state_type;

  rcap_state_type state_r, state_nxt;
  logic [2:0]     idx_r, idx_nxt;
  logic [2:0]     rd_kind_r, rd_kind_nxt;
  logic [4:0]     disp_ptr_r;
  logic [3:0]     rtc_ptr_r;
  logic [7:0]     shift_r;
  logic [7:0]     disp_mem_r [0:DISP_DEPTH-1];
  rcap_cfg_type   cfg_r;
  logic [1:0]     aux_o_r;
  logic           rtc_we_r;
  logic [3:0]     rtc_waddr_r;
  logic [7:0]     rtc_wdata_r;
  logic           aux0_s;
  logic           aux1_s;

  rcap_sync u_sync_aux0 (
    .clk      (CLOCK),
    .srst     (SRST),
    .clk_en   (CLK_EN),
    .async_in (AUX_PIN_ZERO_I),
    .sync_out (aux0_s)
  );

  rcap_sync u_sync_aux1 (
    .clk      (CLOCK),
    .srst     (SRST),
    .clk_en   (CLK_EN),
    .async_in (AUX_PIN_ONE_I),
    .sync_out (aux1_s)
  );

  // Decode of the incoming byte
  wire [7:0] rx         = BUS.rx_data;
  wire [1:0] rx_class   = rx[7:6];
  wire [1:0] rx_dsel    = rx[5:4];
  wire [1:0] rx_sub     = rx[1:0];
  wire [4:0] rx_addr    = rx[4:0];
  wire       addr_rtc   = (rx_addr < DISP_FIRST);                            // RULE14
  wire       addr_disp  = (rx_addr >= DISP_FIRST) && (rx_addr <= DISP_LAST); // RULE14
  wire       byte_in    = CLK_EN && BUS.rx_valid;
  wire       tx_load    = CLK_EN && BUS.tx_req && (state_r == ST_READ);

  // Pointer advance; fixed mode holds the pointer
  wire       adv        = !FIXED_ADDR;                                      // RULE15
  wire [4:0] disp_inc   = (disp_ptr_r == DISP_LAST) ? DISP_FIRST             // RULE13
                                                     : disp_ptr_r + 5'h01;   // RULE14
  wire [3:0] rtc_inc    = rtc_ptr_r + 4'h1;
  wire [2:0] disp_off   = disp_ptr_r[2:0];
  wire [2:0] idx_inc    = (idx_r == 3'h7) ? idx_r : idx_r + 3'h1;

  wire wr_disp = byte_in && (state_r == ST_WR_DISP);
  wire wr_rtc  = byte_in && (state_r == ST_WR_RTC);
  wire rd_disp = tx_load && (rd_kind_r == RD_DISP);
  wire rd_rtc  = tx_load && (rd_kind_r == RD_RTC);

  // Configuration byte picked by read index, least significant first
  logic [7:0] cfg_byte;
  always_comb begin
    case (idx_r)
      3'h0:    cfg_byte = cfg_r.out_format;                                 // RULE19
      3'h1:    cfg_byte = cfg_r.display_pin;
      3'h2:    cfg_byte = cfg_r.brightness;
      3'h3:    cfg_byte = cfg_r.wake_bank_one;
      3'h4:    cfg_byte = cfg_r.wake_bank_two;
      default: cfg_byte = IDLE_BYTE;
    endcase
  end

  // Next read byte; bytes past a fixed length read as the idle filler
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = IDLE_BYTE;
    case (rd_kind_r)
      RD_KEY:  if (idx_r < NB_KEY) rd_byte = KEY_DATA[idx_r[0]*8 +: 8];       // RULE3
      RD_AUX:  if (idx_r < NB_AUX) rd_byte = {aux1_s, aux0_s, 6'h00};        // RULE4
      RD_REMOTE: if (idx_r < NB_REMOTE) rd_byte = REMOTE_DATA[idx_r[1:0]*8 +: 8]; // RULE5
      RD_IRQ:  if (idx_r < NB_IRQ) rd_byte = IRQ_STATUS[idx_r[0]*8 +: 8];    // RULE6
      RD_RSVD: rd_byte = IDLE_BYTE;                                           // RULE7
      RD_CFG:  rd_byte = cfg_byte;                                            // RULE7
      RD_DISP: rd_byte = disp_mem_r[disp_off];                                // RULE8
      RD_RTC:  rd_byte = RTC_RDATA;                                           // RULE16
      default: rd_byte = IDLE_BYTE;
    endcase
  end

  // Command and data-byte sequencing
  always_comb begin
    state_nxt   = state_r;
    idx_nxt     = idx_r;
    rd_kind_nxt = rd_kind_r;
    if (CLK_EN) begin
      if (BUS.start) begin
        state_nxt = ST_CMD;                                                   // RULE1
        idx_nxt   = 3'h0;
      end else if (BUS.stop) begin
        state_nxt = ST_IDLE;                                                  // RULE1
      end else if (BUS.nack && state_r == ST_READ) begin
        state_nxt = ST_IGNORE;                                                // RULE22
      end else if (tx_load) begin
        idx_nxt = idx_inc;
      end else if (BUS.rx_valid) begin
        case (state_r)
          ST_CMD: begin
            idx_nxt = 3'h0;
            case (rx_class)
              CMD_CONFIG: state_nxt = ST_CFG;
              CMD_DATA: begin                                                 // RULE2
                case (rx_dsel)
                  DSEL_WRITE: begin
                    case (rx_sub)
                      WSEL_RTC: state_nxt = ST_WR_RTC;                        // RULE17
                      WSEL_AUX: state_nxt = ST_WR_AUX;
                      default:  state_nxt = ST_WR_DISP;                       // RULE18
                    endcase
                  end
                  DSEL_READ1, DSEL_READ3: begin
                    state_nxt   = ST_READ;
                    rd_kind_nxt = {rx_dsel[0], rx_sub};                       // RULE2
                  end
                  default: state_nxt = ST_IGNORE;
                endcase
              end
              CMD_DISPCTRL: begin
                if (rx[DC_HOTKEY_BIT] && rx_sub == DC_FP_HOTKEY) begin
                  state_nxt = ST_HOTKEY;
                end else begin
                  state_nxt = ST_IGNORE;
                end
              end
              default: begin                                                  // RULE11
                if (addr_rtc) begin
                  state_nxt = ST_WR_RTC;
                end else if (addr_disp) begin
                  state_nxt = ST_WR_DISP;
                end else begin
                  state_nxt = ST_IGNORE;
                end
              end
            endcase
          end
          ST_CFG, ST_HOTKEY: begin
            idx_nxt = idx_inc;
            if (idx_r == 3'h1) begin
              state_nxt = ST_IGNORE;
            end
          end
          ST_WR_AUX: state_nxt = ST_IGNORE;
          default:   state_nxt = state_r;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_r   <= ST_IDLE;
      idx_r     <= 3'h0;
      rd_kind_r <= RD_RSVD;
    end else begin
      state_r   <= state_nxt;
      idx_r     <= idx_nxt;
      rd_kind_r <= rd_kind_nxt;
    end
  end

  // Two pointers held apart so each space resumes where it stopped
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      disp_ptr_r <= DISP_FIRST;                                               // RULE10
      rtc_ptr_r  <= RTC_RESET;
    end else if (CLK_EN) begin
      if (byte_in && state_r == ST_CMD && rx_class == CMD_ADDRESS) begin
        if (addr_rtc) begin
          rtc_ptr_r <= rx_addr[3:0];                                          // RULE14
        end else if (addr_disp) begin
          disp_ptr_r <= rx_addr;                                              // RULE14
        end
      end else if ((wr_disp || rd_disp) && adv) begin
        disp_ptr_r <= disp_inc;                                               // RULE12
      end else if ((wr_rtc || rd_rtc) && adv) begin
        rtc_ptr_r <= rtc_inc;                                                 // RULE11
      end
    end
  end

  // Display memory
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      for (int i = 0; i < DISP_DEPTH; i++) begin
        disp_mem_r[i] <= 8'h00;
      end
    end else if (CLK_EN && wr_disp) begin
      disp_mem_r[disp_off] <= rx;                                             // RULE18
    end
  end

  // Clock register write port, address captured before the pointer moves
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rtc_we_r    <= 1'b0;
      rtc_waddr_r <= RTC_RESET;
      rtc_wdata_r <= 8'h00;
    end else if (CLK_EN) begin
      rtc_we_r <= wr_rtc;
      if (wr_rtc) begin
        rtc_waddr_r <= rtc_ptr_r;                                             // RULE17
        rtc_wdata_r <= rx;
      end
    end
  end

  // Configuration bytes and aux output data
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg_r.out_format    <= RST_OUT_FMT;
      cfg_r.display_pin   <= RST_DISP_PIN;
      cfg_r.brightness    <= RST_BRIGHT;
      cfg_r.wake_bank_one <= RST_WAKE;
      cfg_r.wake_bank_two <= RST_WAKE;
      aux_o_r             <= 2'h0;
    end else if (CLK_EN && byte_in) begin
      if (state_r == ST_CFG && idx_r == 3'h0) begin
        cfg_r.out_format <= rx;
      end
      if (state_r == ST_CFG && idx_r == 3'h1) begin
        cfg_r.display_pin <= rx;                                              // RULE20
      end
      if (state_r == ST_HOTKEY && idx_r == 3'h0) begin
        cfg_r.wake_bank_one <= rx;
      end
      if (state_r == ST_HOTKEY && idx_r == 3'h1) begin
        cfg_r.wake_bank_two <= rx;
      end
      if (state_r == ST_CMD && rx_class == CMD_DISPCTRL && !rx[DC_HOTKEY_BIT]) begin
        cfg_r.brightness <= {3'h0, rx[4:0]};                                  // RULE21
      end
      if (state_r == ST_WR_AUX) begin
        aux_o_r <= rx[7:6];
      end
    end
  end

  // Read shifter: loaded on request, leaves bit 7 first
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      shift_r <= IDLE_BYTE;
    end else if (CLK_EN) begin
      if (BUS.tx_req) begin
        shift_r <= tx_load ? rd_byte : IDLE_BYTE;
      end else if (BUS.bit_adv) begin
        shift_r <= {shift_r[6:0], 1'b1};                                      // RULE22
      end
    end
  end

  assign TX_BIT    = shift_r[7];
  assign RTC_ADDR  = rtc_ptr_r;
  assign RTC_WE    = rtc_we_r;
  assign RTC_WADDR = rtc_waddr_r;
  assign RTC_WDATA = rtc_wdata_r;
  assign CFG       = cfg_r;
  assign AUX_O     = aux_o_r;
  assign AUX_OE    = {cfg_r.display_pin[DP_AUX1_DIR], cfg_r.display_pin[DP_AUX0_DIR]};
  assign DISP_MEM  = {disp_mem_r[4], disp_mem_r[3], disp_mem_r[2], disp_mem_r[1],
                      disp_mem_r[0]};
endmodule
`default_nettype wire

// *** verif/rcap_assertions.sv ***
// Port-level checks of the read-command and address-pointer block.
// Assumes one CLOCK domain and synchronous active-high SRST.
`default_nettype none
module rcap_assertions (
  // Clock and control
  input wire logic                   CLOCK,
  input wire logic                   SRST,
  input wire logic                   CLK_EN,
  input wire logic                   FIXED_ADDR,
  // Byte link
  input wire rcap_pkg::rcap_bus_type BUS,
  input wire logic                   TX_BIT,
  // Observed state
  input wire logic [3:0]             RTC_ADDR,
  input wire logic                   RTC_WE,
  input wire logic [3:0]             RTC_WADDR,
  input wire logic [1:0]             AUX_OE,
  input wire rcap_pkg::rcap_cfg_type CFG,
  input wire logic [39:0]            DISP_MEM
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcap_pkg::*;
  wire logic rx = BUS.rx_valid && CLK_EN;
  wire logic tx = BUS.tx_req && CLK_EN;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  reset_state_a: assert property ($fell(SRST) |-> TX_BIT && RTC_ADDR == 4'h0
    && !RTC_WE && DISP_MEM == 40'h0 && CFG.display_pin == RST_DISP_PIN
    && CFG.out_format == RST_OUT_FMT && CFG.brightness == RST_BRIGHT)
    else $error("state after reset wrong");
  we_cause_a: assert property (RTC_WE |-> $past(rx))
    else $error("clock write without received byte");
  we_advance_a: assert property (RTC_WE && !$past(FIXED_ADDR) |->
    RTC_ADDR == RTC_WADDR + 4'h1)
    else $error("clock pointer did not advance");
  oe_follow_a: assert property (!$stable(AUX_OE) |-> $past(rx)
    && AUX_OE == $past(BUS.rx_data[DP_AUX1_DIR:DP_AUX0_DIR]))
    else $error("pin enables differ from direction bits");
  disp_cause_a: assert property (!$stable(DISP_MEM) |-> $past(rx))
    else $error("display memory changed without a byte");
  rtc_cause_a: assert property (!$stable(RTC_ADDR) |-> $past(rx || tx))
    else $error("clock pointer moved without cause");
  cfg_first_a: assert property (BUS.start && CLK_EN ##1 rx && BUS.rx_data == 8'h71
    ##1 tx |=> TX_BIT == CFG.out_format[7])
    else $error("first configuration bit wrong");
  wrap_pair_a: assert property (BUS.start && CLK_EN ##1 rx && BUS.rx_data == 8'hD4
    ##1 rx && !FIXED_ADDR ##1 rx |=> DISP_MEM[7:0] == $past(BUS.rx_data)
    && DISP_MEM[39:32] == $past(BUS.rx_data, 2))
    else $error("display pointer did not wrap");
endmodule
bind rcap_top rcap_assertions i_rcap_assertions (.CLOCK(CLOCK), .SRST(SRST),
  .CLK_EN(CLK_EN), .FIXED_ADDR(FIXED_ADDR), .BUS(BUS), .TX_BIT(TX_BIT),
  .RTC_ADDR(RTC_ADDR), .RTC_WE(RTC_WE), .RTC_WADDR(RTC_WADDR), .AUX_OE(AUX_OE),
  .CFG(CFG), .DISP_MEM(DISP_MEM));
`default_nettype wire

// *** verif/rcap_host.sv ***
// Host bus-master model driving the byte strobes of the block.
// Assumes one caller at a time; strobes change at the falling edge.
`default_nettype none
module rcap_host (
  // Clock
  input  wire logic                  CLOCK,
  // Byte link
  output var rcap_pkg::rcap_bus_type BUS,
  input  wire logic                  TX_BIT
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcap_pkg::*;
  // Packed order: start, stop, rx_valid, rx_data, tx_req, bit_adv, nack
  initial BUS = '0;
  task automatic put(input rcap_bus_type v);
    @(negedge CLOCK);
    BUS <= v;
  endtask
  task automatic send(input logic [7:0] d);
    put({3'h1, d, 3'h0});
  endtask
  task automatic cmd_start(input logic [7:0] c);
    put(14'h2000);
    send(c);
  endtask
  task automatic finish_xfer(input logic rd);
    if (rd)
      put(14'h0001);
    put(14'h1000);
    put(14'h0000);
  endtask
  // The line is sampled just before each advance, so eight samples need seven advances
  task automatic recv(output logic [7:0] d);
    put(14'h0004);
    for (int i = 7; i >= 0; i--) begin
      put(i == 0 ? 14'h0000 : 14'h0002);
      d[i] = TX_BIT;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/rcap_top_tb.sv ***
// Self-checking bench of the block against an integer model of pointers and memories.
// Assumes the host model and the bound checker; the bench plays the clock registers.
`default_nettype none
module rcap_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcap_pkg::*;
  logic         CLOCK = 1'b0;
  logic         SRST = 1'b1;
  logic         CLK_EN = 1'b1;
  logic         FIXED_ADDR = 1'b0;
  logic         AUX_PIN_ZERO_I = 1'b0;
  logic         AUX_PIN_ONE_I = 1'b0;
  logic [15:0]  KEY_DATA = 16'h0, IRQ_STATUS = 16'h0;
  logic [31:0]  REMOTE_DATA = 32'h0, src, lfsr = 32'h1FC02D14;
  rcap_bus_type BUS;
  rcap_cfg_type CFG;
  logic         TX_BIT, RTC_WE;
  logic [3:0]   RTC_ADDR, RTC_WADDR;
  logic [7:0]   RTC_WDATA, RTC_RDATA, b, d;
  logic [1:0]   AUX_O, AUX_OE;
  logic [39:0]  DISP_MEM;
  logic [7:0]   rtc_mem [16], m_rtc [16], m_disp [5], m_cfg [5];
  int           m_dptr, m_cptr, nb [4];
  int           fail_count = 0;
  int           checks_done = 0;
  rcap_host i_rcap_host (.CLOCK(CLOCK), .BUS(BUS), .TX_BIT(TX_BIT));
  rcap_top i_rcap_top (.CLOCK(CLOCK), .SRST(SRST), .CLK_EN(CLK_EN), .BUS(BUS),
    .TX_BIT(TX_BIT), .FIXED_ADDR(FIXED_ADDR), .KEY_DATA(KEY_DATA),
    .REMOTE_DATA(REMOTE_DATA),
    .IRQ_STATUS(IRQ_STATUS), .RTC_ADDR(RTC_ADDR), .RTC_RDATA(RTC_RDATA), .RTC_WE(RTC_WE),
    .RTC_WADDR(RTC_WADDR), .RTC_WDATA(RTC_WDATA), .AUX_PIN_ZERO_I(AUX_PIN_ZERO_I),
    .AUX_PIN_ONE_I(AUX_PIN_ONE_I), .AUX_O(AUX_O), .AUX_OE(AUX_OE), .CFG(CFG),
    .DISP_MEM(DISP_MEM));
  always #4 CLOCK = ~CLOCK;
  assign RTC_RDATA = rtc_mem[RTC_ADDR];
  always @(posedge CLOCK)
    if (RTC_WE)
      rtc_mem[RTC_WADDR] <= RTC_WDATA;
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
    checks_done++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic go(input logic [7:0] c);
    i_rcap_host.cmd_start(c);
  endtask
  task automatic fin(input logic rd);
    i_rcap_host.finish_xfer(rd);
    chk("display memory", {m_disp[4], m_disp[3], m_disp[2], m_disp[1], m_disp[0]}, DISP_MEM);
    chk("configuration", {m_cfg[4], m_cfg[3], m_cfg[2], m_cfg[1], m_cfg[0]}, CFG);
  endtask
  task automatic adv(input logic rtc);
    if (!FIXED_ADDR && rtc)
      m_cptr = (m_cptr + 1) % 16;
    if (!FIXED_ADDR && !rtc)
      m_dptr = (m_dptr == 20) ? 16 : m_dptr + 1;
  endtask
  task automatic wr(input logic rtc, input logic [7:0] v);
    i_rcap_host.send(v);
    if (rtc)
      m_rtc[m_cptr] = v;
    else
      m_disp[m_dptr - 16] = v;
    adv(rtc);
  endtask
  task automatic rd(input string n, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    i_rcap_host.recv(d);
    chk(n, e & m, d & m);
  endtask
  task automatic cfg_read();
    go(8'h71);
    for (int i = 0; i <= 5; i++)
      rd("configuration read", (i == 5) ? IDLE_BYTE : m_cfg[i]);
    fin(1'b1);
  endtask
  task automatic do_reset();
    SRST = 1'b1;
    repeat (8) @(negedge CLOCK);
    SRST = 1'b0;
    m_dptr = 16;
    m_cptr = 0;
    m_disp = '{default: 8'h00};
    m_cfg = '{RST_OUT_FMT, RST_DISP_PIN, RST_BRIGHT, RST_WAKE, RST_WAKE};
  endtask
  // Limit of 12500 cycles, far above the few hundred cycles the sequence needs
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    foreach (rtc_mem[i]) begin
      rtc_mem[i] = 8'h80 + 8'(i);
      m_rtc[i] = 8'h80 + 8'(i);
    end
    do_reset();
    chk("clock pointer", 40'h0, RTC_ADDR);
    chk("aux output", 40'h0, AUX_O);
    fin(1'b0);
    cfg_read();
    $display("test reset state done");
    go(8'hD4);
    m_dptr = 20;
    repeat (6) wr(1'b0, rnd8());
    fin(1'b0);
    go(8'h41);
    repeat (2) wr(1'b0, rnd8());
    fin(1'b0);
    FIXED_ADDR = 1'b1;
    go(8'hD2);
    m_dptr = 18;
    repeat (2) wr(1'b0, rnd8());
    fin(1'b0);
    FIXED_ADDR = 1'b0;
    $display("test display pointer done");
    go(8'hC3);
    m_cptr = 3;
    repeat (2) wr(1'b1, rnd8());
    fin(1'b0);
    go(8'hD1);
    m_dptr = 17;
    fin(1'b0);
    go(8'h40);
    wr(1'b1, rnd8());
    fin(1'b0);
    go(8'h41);
    wr(1'b0, rnd8());
    fin(1'b0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        go(8'hC2);
        m_cptr = 2;
        fin(1'b0);
      end
      go(8'h73);
      repeat (2) begin
        rd("clock read", m_rtc[m_cptr]);
        adv(1'b1);
      end
      fin(1'b1);
    end
    go(8'h72);
    repeat (2) begin
      rd("display read", m_disp[m_dptr - 16]);
      adv(1'b0);
    end
    fin(1'b1);
    go(8'h70);
    rd("reserved read", IDLE_BYTE);
    fin(1'b1);
    $display("test clock and group three done");
    KEY_DATA = {rnd8(), rnd8()};
    REMOTE_DATA = {rnd8(), rnd8(), rnd8(), rnd8()};
    IRQ_STATUS = {rnd8(), rnd8()};
    b = rnd8();
    AUX_PIN_ONE_I = b[7];
    AUX_PIN_ZERO_I = b[6];
    repeat (4) @(negedge CLOCK);
    nb = '{int'(NB_KEY), int'(NB_AUX), int'(NB_REMOTE), int'(NB_IRQ)};
    for (int s = 0; s < 4; s++) begin
      src = (s == 0) ? KEY_DATA : (s == 1) ? {24'h0, b[7:6], 6'h0} : (s == 2) ? REMOTE_DATA
        : IRQ_STATUS;
      go(8'h60 + 8'(s));
      for (int i = 0; i <= nb[s]; i++)
        rd("group one read", (i == nb[s]) ? IDLE_BYTE : 8'(src >> (8 * i)),
          (s == 1 && i == 0) ? 8'hC0 : 8'hFF);
      fin(1'b1);
    end
    // Pin output write takes bits 7 and 6 of the one following byte
    go(8'h43);
    i_rcap_host.send(b);
    fin(1'b0);
    chk("aux output", b[7:6], AUX_O);
    $display("test group one done");
    go(8'h00);
    m_cfg[0] = rnd8();
    m_cfg[1] = rnd8();
    i_rcap_host.send(m_cfg[0]);
    i_rcap_host.send(m_cfg[1]);
    fin(1'b0);
    chk("pin direction", m_cfg[1][4:3], AUX_OE);
    b = rnd8();
    go({3'h4, b[4:0]});
    m_cfg[2] = {3'h0, b[4:0]};
    fin(1'b0);
    go(8'hA2);
    m_cfg[3] = rnd8();
    m_cfg[4] = rnd8();
    i_rcap_host.send(m_cfg[3]);
    i_rcap_host.send(m_cfg[4]);
    fin(1'b0);
    cfg_read();
    $display("test configuration done");
    // A byte under a low enable, then one with no start, must both be dropped
    go(8'hD0);
    m_dptr = 16;
    i_rcap_host.put(14'h0000);
    CLK_EN = 1'b0;
    i_rcap_host.send(8'h5A);
    i_rcap_host.put(14'h0000);
    CLK_EN = 1'b1;
    fin(1'b0);
    i_rcap_host.send(8'hA5);
    fin(1'b0);
    // Second write command and an address past display memory are both ignored
    go(8'h53);
    i_rcap_host.send(8'h3C);
    go(8'hD7);
    i_rcap_host.send(8'hC3);
    fin(1'b0);
    do_reset();
    fin(1'b0);
    chk("aux output", 40'h0, AUX_O);
    $display("test refusals and second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
